// [spfs_buf_if.sv]
`timescale 1ns/10ps
`default_nettype none
// temporary page buffer port between sequencer and storage
interface spfs_buf_if #(parameter int WB = 7);
  logic          wrEn;    // load one word
  logic [WB-1:0] wrAddr;  // word within page
  logic [15:0]   wrData;  // data pair
  logic          clr;     // discard every loaded word
  logic [WB-1:0] rdAddr;  // readout address
  logic [15:0]   rdData;  // registered readout
  modport seq (output wrEn, wrAddr, wrData, clr, rdAddr, input rdData);
  modport mem (input wrEn, wrAddr, wrData, clr, rdAddr, output rdData);
endinterface
`default_nettype wire

// [spfs_cpu_model.sv]
`timescale 1ns/10ps
`default_nettype none
// behavioural core: register file pointer, data pair and instruction strobes
module spfs_cpu_model (
  // clock
  input  wire logic        clk,
  // control register write
  output var  logic        ctrlWrEn,
  output var  logic [7:0]  ctrlWrData,
  // pointer bytes and data pair
  output var  logic [7:0]  ptrExt,
  output var  logic [7:0]  ptrHigh,
  output var  logic [7:0]  ptrLow,
  output var  logic [15:0] dataPair,
  // instruction strobes
  output var  logic        spmExec,
  output var  logic        lpmExec,
  output var  logic        eepromWrite
);
  import spfs_pkg::*;

  // quiet values; the bench calls this at time zero, before the first edge
  task automatic quiet;
    ctrlWrEn    = 1'b0;
    ctrlWrData  = 8'h00;
    {ptrExt, ptrHigh, ptrLow} = 24'h000000;
    dataPair    = 16'h0000;
    spmExec     = 1'b0;
    lpmExec     = 1'b0;
    eepromWrite = 1'b0;
  endtask

  // pointer bytes are registers: they hold until rewritten
  task automatic setPtr(input logic [23:0] a);
    @(negedge clk);
    {ptrExt, ptrHigh, ptrLow} = a;
  endtask

  // one register write, returns just after the taking edge
  task automatic wrCtrl(input logic [7:0] v);
    @(negedge clk);
    ctrlWrEn   = 1'b1;
    ctrlWrData = v;
    @(negedge clk);
    ctrlWrEn   = 1'b0;
  endtask

  // store after gap idle cycles; interrupts are masked, so nothing stretches it
  task automatic spm(input int gap);
    repeat (gap) @(negedge clk);
    spmExec = 1'b1;
    @(negedge clk);
    spmExec = 1'b0;
  endtask

  // command followed by its store
  task automatic issue(input logic [7:0] v, input logic [15:0] d, input int gap);
    dataPair = d;
    wrCtrl(v);
    spm(gap);
  endtask

  // one byte read or one eeprom write pulse
  task automatic strobe(input logic rd);
    @(negedge clk);
    lpmExec     = rd;
    eepromWrite = !rd;
    @(negedge clk);
    lpmExec     = 1'b0;
    eepromWrite = 1'b0;
  endtask
endmodule // spfs_cpu_model
`default_nettype wire

// [spfs_op_timer.sv]
`timescale 1ns/10ps
`default_nettype none
module spfs_op_timer #(
  parameter int CYCLES = spfs_pkg::OP_MIN_CYCLES
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic nrst,
  // control
  input  wire logic start,
  output var  logic done
);
  import spfs_pkg::*;
  localparam int CW = $clog2(CYCLES + 1);
  if (CYCLES < 2) begin : g_bad_cycles
    $error("CYCLES must be at least 2");
  end
  typedef struct packed {
    logic [CW-1:0] cnt;   // cycles left
    logic          run;   // counting
    logic          done;  // one-cycle end pulse
  } spfs_tmr_state_t;
  spfs_tmr_state_t s_q, s_d;

  // single down counter; stands in for the oscillator-timed flash pulse
  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    if (start) begin
      s_d.cnt = CW'(CYCLES - 1);
      s_d.run = 1'b1;
    end else if (s_q.run) begin
      if (s_q.cnt == '0) begin
        s_d.run  = 1'b0;
        s_d.done = 1'b1;
      end else begin
        s_d.cnt = s_q.cnt - 1'b1;
      end
    end
  end

  // state register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign done = s_q.done;
endmodule // spfs_op_timer
`default_nettype wire

// [spfs_page_buffer.sv]
`timescale 1ns/10ps
`default_nettype none
module spfs_page_buffer #(
  parameter int WORDS = spfs_pkg::PAGE_WORDS_DEF
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // buffer port
  spfs_buf_if.mem  bus
);
  import spfs_pkg::*;
  if (WORDS < 2 || (WORDS & (WORDS - 1)) != 0) begin : g_bad_words
    $error("WORDS must be a power of two");
  end
  typedef struct packed {
    logic [WORDS-1:0][15:0] mem;    // word storage
    logic [WORDS-1:0]       valid;  // word loaded since last clear
    logic [15:0]            rd;     // readout register
  } spfs_buf_state_t;
  spfs_buf_state_t s_q, s_d;

  // clear drops valid marks only, so a whole-page clear costs one cycle
  always_comb begin
    s_d = s_q;
    s_d.rd = s_q.valid[bus.rdAddr] ? s_q.mem[bus.rdAddr] : ERASED_WORD;
    if (bus.clr) begin
      s_d.valid = '0;
    end
    // any address order is fine; each word has its own slot
    if (bus.wrEn) begin
      s_d.mem[bus.wrAddr]   = bus.wrData;
      s_d.valid[bus.wrAddr] = 1'b1;
    end
  end

  // storage register; system reset empties the buffer
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign bus.rdData = s_q.rd;
endmodule // spfs_page_buffer
`default_nettype wire

// [spfs_pkg.sv]
package spfs_pkg;
  // clock rate
  localparam real CLK_PERIOD_NS    = 10.0;
  // control/status register field positions
  localparam int  CTRL_EN_BIT      = 0;   // operation enable
  localparam int  CTRL_ERASE_BIT   = 1;   // page erase select
  localparam int  CTRL_WRITE_BIT   = 2;   // page write select
  localparam int  CTRL_REEN_BIT    = 4;   // concurrent section re-enable
  localparam int  CTRL_BUSY_BIT    = 6;   // concurrent section busy, read only
  localparam int  CTRL_IE_BIT      = 7;   // completion interrupt enable
  localparam logic [7:0] CTRL_RESET = 8'h00;
  // command codes on bits 6..0; bit 7 is the interrupt enable
  localparam logic [6:0] CMD_LOAD  = 7'h01;
  localparam logic [6:0] CMD_ERASE = 7'h03;
  localparam logic [6:0] CMD_WRITE = 7'h05;
  localparam logic [6:0] CMD_REEN  = 7'h11;
  // store instruction must follow the command within this many cycles
  localparam logic [2:0] WINDOW_CYCLES = 3'h4;
  // programming time per operation
  localparam real OP_MIN_MS = 3.7;
  localparam real OP_MAX_MS = 4.5;
  localparam int  OP_MIN_CYCLES = int'($ceil(OP_MIN_MS * 1.0e6 / CLK_PERIOD_NS - 1.0e-6));
  localparam int  OP_MAX_CYCLES = int'($floor(OP_MAX_MS * 1.0e6 / CLK_PERIOD_NS + 1.0e-6));
  // geometry defaults
  localparam int  FLASH_BYTES_DEF   = 131072;
  localparam int  PAGE_WORDS_DEF    = 128;
  localparam int  BOOT_START_DEF    = 'h1F000;  // boot loader start word
  localparam int  HALT_FIRST_PAGE   = 480;      // first page of halting section
  localparam int  EXT_NEEDED_BYTES  = 65536;    // above this the extension byte exists
  localparam logic [15:0] ERASED_WORD = 16'hFFFF;
  // sequencer states
  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_ARMED,
    SEQ_OP
  } spfs_state_t;
endpackage

// [spfs_sequencer.sv]
`timescale 1ns/10ps
`default_nettype none
module spfs_sequencer #(
  parameter int FLASH_BYTES = spfs_pkg::FLASH_BYTES_DEF,
  parameter int PAGE_WORDS  = spfs_pkg::PAGE_WORDS_DEF,
  parameter int BOOT_START  = spfs_pkg::BOOT_START_DEF,
  parameter int HALT_PAGE   = spfs_pkg::HALT_FIRST_PAGE,
  parameter int OP_CYCLES   = spfs_pkg::OP_MIN_CYCLES
) (
  // clock and reset
  input  wire logic                                clk,
  input  wire logic                                nrst,
  // boot fuse, input only
  input  wire logic                                bootFuse,
  output var  logic [$clog2(FLASH_BYTES)-2:0]      resetVector,
  // control/status register access
  input  wire logic                                ctrlWrEn,
  input  wire logic [7:0]                          ctrlWrData,
  output var  logic [7:0]                          ctrlRdData,
  // pointer and data from the core
  input  wire logic [7:0]                          ptrExt,
  input  wire logic [7:0]                          ptrHigh,
  input  wire logic [7:0]                          ptrLow,
  input  wire logic [15:0]                         dataPair,
  // instruction strobes
  input  wire logic                                spmExec,
  input  wire logic                                lpmExec,
  input  wire logic                                eepromWrite,
  // byte read address
  output var  logic [$clog2(FLASH_BYTES)-2:0]      lpmWordAddr,
  output var  logic                                lpmByteSel,
  // core and section status
  output var  logic                                cpuHalt,
  output var  logic                                rwReadBlock,
  output var  logic                                flashIrq,
  // flash array side
  output var  logic                                flashErase,
  output var  logic                                flashWrite,
  output var  logic [$clog2(FLASH_BYTES)-$clog2(PAGE_WORDS)-2:0] flashPage,
  output var  logic                                progValid,
  output var  logic [$clog2(PAGE_WORDS)-1:0]       progAddr,
  output var  logic [15:0]                         progData
);
  import spfs_pkg::*;
  localparam int AB = $clog2(FLASH_BYTES);  // byte address bits
  localparam int WB = $clog2(PAGE_WORDS);   // word-in-page bits
  localparam int PB = AB - 1 - WB;          // page bits
  if ((FLASH_BYTES & (FLASH_BYTES - 1)) != 0 || AB > 24 || AB < WB + 3) begin : g_bad_flash
    $error("FLASH_BYTES unsupported");
  end
  if (PAGE_WORDS < 2 || (PAGE_WORDS & (PAGE_WORDS - 1)) != 0) begin : g_bad_page
    $error("PAGE_WORDS must be a power of two");
  end

  typedef struct packed {
    spfs_state_t    st;       // sequencer state
    logic [2:0]     win;      // store window left
    logic           ie;       // interrupt enable
    logic           en;       // operation enable
    logic           ers;      // erase selected
    logic           wrt;      // write selected
    logic           busy;     // concurrent section busy
    logic           halt;     // core halted
    logic           caught;   // boot fuse sampled
    logic [AB-2:0]  vec;      // reset vector
    logic [PB-1:0]  page;     // latched target page
    logic           strm;     // buffer readout running
    logic [WB-1:0]  idx;      // readout index
    logic           pVld;     // readout word valid
    logic [WB-1:0]  pAddr;    // readout word address
    logic [AB-2:0]  lAddr;    // byte read word address
    logic           lSel;     // byte read byte select
    logic           irq;      // interrupt level
    logic [7:0]     rd;       // register readback
  } spfs_seq_state_t;
  spfs_seq_state_t s_q, s_d;

  logic [23:0]   ptr;        // composite pointer
  logic [6:0]    cmd;        // written command code
  logic          bufWr;      // buffer load strobe
  logic          bufClr;     // buffer clear strobe
  logic          tmrStart;   // start programming timer
  logic          tmrDone;    // programming time over

  spfs_buf_if #(.WB(WB)) bif ();

  // page buffer storage
  spfs_page_buffer #(.WORDS(PAGE_WORDS)) u_buf (
    .clk  (clk),
    .nrst (nrst),
    .bus  (bif)
  );

  // programming time base
  spfs_op_timer #(.CYCLES(OP_CYCLES)) u_tmr (
    .clk   (clk),
    .nrst  (nrst),
    .start (tmrStart),
    .done  (tmrDone)
  );

  // extension byte only exists on parts above 64K bytes
  assign ptr = {((FLASH_BYTES > EXT_NEEDED_BYTES) ? ptrExt : 8'h00), ptrHigh, ptrLow};
  assign cmd = ctrlWrData[6:0];

  // buffer port: loads take the word field, data pair as given
  assign bif.wrEn   = bufWr;
  assign bif.wrAddr = ptr[WB:1];
  assign bif.wrData = dataPair;
  assign bif.clr    = bufClr;
  assign bif.rdAddr = s_q.idx;

  // next-state logic
  always_comb begin
    s_d      = s_q;
    bufWr    = 1'b0;
    bufClr   = 1'b0;
    tmrStart = 1'b0;
    // fuse has no write path; sampled once after reset release
    if (!s_q.caught) begin
      s_d.caught = 1'b1;
      s_d.vec    = bootFuse ? '0 : (AB-1)'(BOOT_START);
    end
    // interrupt enable may change in any state
    if (ctrlWrEn) begin
      s_d.ie = ctrlWrData[CTRL_IE_BIT];
    end
    case (s_q.st)
      SEQ_IDLE: begin
        if (ctrlWrEn && cmd == CMD_REEN) begin
          s_d.busy = 1'b0;
          bufClr   = 1'b1;
        end else if (ctrlWrEn && (cmd == CMD_LOAD || cmd == CMD_ERASE || cmd == CMD_WRITE)) begin
          s_d.en  = 1'b1;
          s_d.ers = cmd[CTRL_ERASE_BIT];
          s_d.wrt = cmd[CTRL_WRITE_BIT];
          s_d.win = WINDOW_CYCLES;
          s_d.st  = SEQ_ARMED;
        end
      end
      SEQ_ARMED: begin
        if (spmExec) begin
          if (!s_q.ers && !s_q.wrt) begin
            bufWr  = 1'b1;
            s_d.en = 1'b0;
            s_d.st = SEQ_IDLE;
          end else begin
            // only the page field is used; data and word bits ignored
            s_d.page = ptr[AB-1:WB+1];
            s_d.busy = 1'b1;
            s_d.halt = (ptr[AB-1:WB+1] >= PB'(HALT_PAGE));
            s_d.strm = s_q.wrt;
            s_d.idx  = '0;
            tmrStart = 1'b1;
            s_d.st   = SEQ_OP;
          end
        end else if (s_q.win == 3'h1) begin
          s_d.en  = 1'b0;
          s_d.ers = 1'b0;
          s_d.wrt = 1'b0;
          s_d.st  = SEQ_IDLE;
        end else begin
          s_d.win = s_q.win - 1'b1;
        end
      end
      SEQ_OP: begin
        // enable stays set until the timer ends the operation
        if (tmrDone) begin
          bufClr  = s_q.wrt;
          s_d.en  = 1'b0;
          s_d.ers = 1'b0;
          s_d.wrt = 1'b0;
          s_d.halt = 1'b0;
          s_d.st  = SEQ_IDLE;
        end
      end
      default: begin
        s_d.st = SEQ_IDLE;
      end
    endcase
    // eeprom write loses loaded words; not during an erase or write operation
    if (eepromWrite && s_q.st != SEQ_OP) begin
      bufClr = 1'b1;
    end
    // buffer streams out to the array at the start of a page write
    s_d.pVld  = s_q.strm;
    s_d.pAddr = s_q.idx;
    if (s_q.strm) begin
      s_d.idx = s_q.idx + 1'b1;
      if (s_q.idx == WB'(PAGE_WORDS - 1)) begin
        s_d.strm = 1'b0;
      end
    end
    // byte read: pointer is a byte address, bit 0 picks the byte
    if (lpmExec) begin
      s_d.lAddr = ptr[AB-1:1];
      s_d.lSel  = ptr[0];
    end
    // interrupt holds while enabled and the enable bit reads clear
    s_d.irq = s_d.ie && !s_d.en;
    s_d.rd  = '0;
    s_d.rd[CTRL_IE_BIT]    = s_d.ie;
    s_d.rd[CTRL_BUSY_BIT]  = s_d.busy;
    s_d.rd[CTRL_WRITE_BIT] = s_d.wrt;
    s_d.rd[CTRL_ERASE_BIT] = s_d.ers;
    s_d.rd[CTRL_EN_BIT]    = s_d.en;
  end

  // state register; vector reset value is constant, fuse caught after release
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_q    <= '0;
      s_q.st <= SEQ_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs from state flops; erase and write also decode the sequencer state
  assign resetVector = s_q.vec;
  assign ctrlRdData  = s_q.rd;
  assign lpmWordAddr = s_q.lAddr;
  assign lpmByteSel  = s_q.lSel;
  assign cpuHalt     = s_q.halt;
  assign rwReadBlock = s_q.busy;
  assign flashIrq    = s_q.irq;
  assign flashErase  = (s_q.st == SEQ_OP) && s_q.ers;
  assign flashWrite  = (s_q.st == SEQ_OP) && s_q.wrt;
  assign flashPage   = s_q.page;
  assign progValid   = s_q.pVld;
  assign progAddr    = s_q.pAddr;
  assign progData    = bif.rdData;

  // helper: cycles spent in the operation state
  logic [31:0] opLen_q;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      opLen_q <= '0;
    end else begin
      opLen_q <= (s_q.st == SEQ_OP) ? opLen_q + 32'h1 : 32'h0;
    end
  end

  // helpers for the checks below; sampled-value calls want plain signals
  logic          inOp;    // operation state
  logic [AB-1:0] lpmPtr;  // pointer bits a byte read uses
  assign inOp   = (s_q.st == SEQ_OP);
  assign lpmPtr = ptr[AB-1:0];

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  // window and store handling
  chk_window_expiry: assert property (
    (s_q.st == SEQ_ARMED && s_q.win == 3'h1 && !spmExec) |=>
    (!ctrlRdData[CTRL_EN_BIT] && s_q.st == SEQ_IDLE))
    else $error("enable not cleared after window");
  chk_store_starts: assert property (
    (s_q.st == SEQ_ARMED && spmExec && (s_q.ers || s_q.wrt)) |=>
    (inOp && rwReadBlock && (flashErase || flashWrite)))
    else $error("store did not start the operation");
  chk_load_ends: assert property (
    (s_q.st == SEQ_ARMED && spmExec && !s_q.ers && !s_q.wrt) |=>
    (!ctrlRdData[CTRL_EN_BIT] && s_q.st == SEQ_IDLE))
    else $error("enable not cleared after load");
  chk_busy_in_op: assert property (
    inOp |-> ##1 (rwReadBlock && ctrlRdData[CTRL_BUSY_BIT]))
    else $error("busy or block missing in operation");
  chk_reenable_clears: assert property (
    (s_q.st == SEQ_IDLE && ctrlWrEn && cmd == CMD_REEN) |=>
    (!rwReadBlock ##1 !ctrlRdData[CTRL_BUSY_BIT]))
    else $error("reenable did not clear busy");
  // operation checks
  chk_halt_page: assert property (
    $rose(inOp) |-> (cpuHalt == (flashPage >= PB'(HALT_PAGE))))
    else $error("halt does not follow page section");
  chk_halt_only_op: assert property (
    cpuHalt |-> (flashErase || flashWrite))
    else $error("core halted outside an operation");
  chk_irq_level: assert property (
    flashIrq == (ctrlRdData[CTRL_IE_BIT] && !ctrlRdData[CTRL_EN_BIT]))
    else $error("interrupt level wrong");
  chk_page_latched: assert property (
    (inOp && $past(inOp)) |-> $stable(flashPage))
    else $error("page changed during operation");
  chk_op_length: assert property (
    (!inOp && $past(inOp)) |-> (opLen_q == OP_CYCLES + 1))
    else $error("operation length wrong");
  chk_enable_held: assert property (
    inOp |=> (ctrlRdData[CTRL_EN_BIT] || $past(tmrDone)))
    else $error("enable dropped early");
  chk_write_clears: assert property (
    (inOp && s_q.wrt && tmrDone) |=> (u_buf.s_q.valid == '0))
    else $error("buffer kept after write");
  chk_vector_fixed: assert property (
    (s_q.caught && $past(s_q.caught)) |-> $stable(resetVector))
    else $error("reset vector changed");
  chk_byte_read: assert property (
    lpmExec |=> ({lpmWordAddr, lpmByteSel} == $past(lpmPtr)))
    else $error("byte read address wrong");

  cov_erase: cover property (s_q.st == SEQ_OP && s_q.ers ##1 s_q.st == SEQ_IDLE);
  cov_write: cover property (s_q.st == SEQ_OP && s_q.wrt && progValid);
  cov_load:  cover property (bufWr);
  cov_expiry: cover property (s_q.st == SEQ_ARMED && s_q.win == 3'h1 && !spmExec);
  cov_reenable: cover property (s_q.st == SEQ_IDLE && ctrlWrEn && cmd == CMD_REEN);
endmodule // spfs_sequencer
`default_nettype wire

// [testbench.sv]
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import spfs_pkg::*;
  // short operation so the run stays brief; still longer than the 128 word stream
  localparam int OP_CYC = 140;
  localparam int BOOT   = 16'hF000;
  // clock, reset, fuse
  logic        clk = 1'b0;
  logic        nrst;
  logic        bootFuse;
  // core side; the core model drives all but the register readback
  wire logic        ctrlWrEn, spmExec, lpmExec, eepromWrite;
  wire logic [7:0]  ctrlWrData, ptrExt, ptrHigh, ptrLow;
  wire logic [15:0] dataPair;
  logic [7:0]  ctrlRdData;
  // sequencer outputs
  logic [15:0] resetVector, lpmWordAddr, progData;
  logic        lpmByteSel, cpuHalt, rwReadBlock, flashIrq;
  logic        flashErase, flashWrite, progValid;
  logic [8:0]  flashPage;
  logic [6:0]  progAddr;
  // bookkeeping and expected buffer contents
  int          n_fail = 0;
  int          comparisons = 0;
  int          nStream = 0;
  int          cyc = 0;
  logic [15:0] expBuf [128];
  logic [15:0] capt [128];

  spfs_cpu_model cpu (.clk(clk), .ctrlWrEn(ctrlWrEn), .ctrlWrData(ctrlWrData),
    .ptrExt(ptrExt), .ptrHigh(ptrHigh), .ptrLow(ptrLow), .dataPair(dataPair),
    .spmExec(spmExec), .lpmExec(lpmExec), .eepromWrite(eepromWrite));

  spfs_sequencer #(.BOOT_START(BOOT), .OP_CYCLES(OP_CYC)) uut (.clk(clk), .nrst(nrst),
    .bootFuse(bootFuse), .resetVector(resetVector), .ctrlWrEn(ctrlWrEn),
    .ctrlWrData(ctrlWrData), .ctrlRdData(ctrlRdData), .ptrExt(ptrExt), .ptrHigh(ptrHigh),
    .ptrLow(ptrLow), .dataPair(dataPair), .spmExec(spmExec), .lpmExec(lpmExec),
    .eepromWrite(eepromWrite), .lpmWordAddr(lpmWordAddr), .lpmByteSel(lpmByteSel),
    .cpuHalt(cpuHalt), .rwReadBlock(rwReadBlock), .flashIrq(flashIrq),
    .flashErase(flashErase), .flashWrite(flashWrite), .flashPage(flashPage),
    .progValid(progValid), .progAddr(progAddr), .progData(progData));

  // 100 MHz clock
  always #5 clk = ~clk;

  // collect the streamed page; order does not matter, addresses do
  always @(posedge clk) begin
    if (progValid === 1'b1) begin
      capt[progAddr] <= progData;
      nStream <= nStream + 1;
    end
  end

  // hang guard, far above the roughly 1200 cycles the tests need
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      n_fail++;
      summarize();
    end
  end

  // compare and count
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // expected buffer after any clearing event
  task automatic clrBuf;
    foreach (expBuf[i]) expBuf[i] = 16'hFFFF;
  endtask

  // reset held six cycles, fuse steady across it
  task automatic doReset(input logic fuse);
    nrst = 1'b0;
    bootFuse = fuse;
    repeat (6) @(negedge clk);
    nrst = 1'b1;
    repeat (2) @(negedge clk);
    clrBuf;
  endtask

  // one buffer word; page bits in the pointer are ignored by a load
  task automatic load(input logic [6:0] w, input logic [15:0] d, input int gap);
    cpu.setPtr({16'h0105, w, 1'b0});
    cpu.issue(8'h01, d, gap);
    expBuf[w] = d;
    @(negedge clk);
    check("load done", ctrlRdData[0], 1'b0);
  endtask

  // erase or write of one page, with the pointer moved away mid operation
  task automatic opPage(input logic [7:0] code, input logic [23:0] p, input logic halt);
    int d;
    nStream = 0;
    cpu.setPtr(p);
    cpu.issue(code, 16'h0000, 0);
    @(negedge clk);
    check("op kind", {flashErase, flashWrite}, {code[1], code[2]});
    check("busy", {rwReadBlock, ctrlRdData[6]}, 2'h3);
    check("halt", cpuHalt, halt);
    check("irq in op", flashIrq, 1'b0);
    cpu.setPtr(24'h000000);
    check("page", flashPage, p[16:8]);
    d = 0;
    while (ctrlRdData[0] !== 1'b0 && d < 300) begin
      @(negedge clk);
      d++;
    end
    check("duration", d >= OP_CYC - 4 && d <= OP_CYC + 2, 1'b1);
    check("after op", ctrlRdData, {code[7], 7'h40});
    check("irq after", flashIrq, code[7]);
    check("halt off", cpuHalt, 1'b0);
    if (code[2]) begin
      check("stream", nStream, 128);
      for (int i = 0; i < 128; i++) check("word", capt[i], expBuf[i]);
      clrBuf;
    end
  endtask

  // verdict, reached once from either the sequence or the hang guard
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    cpu.quiet();
    nrst = 1'b0;
    bootFuse = 1'b1;
    doReset(1'b1);
    check("vector app", resetVector, 16'h0000);
    check("ctrl reset", ctrlRdData, CTRL_RESET);
    doReset(1'b0);
    check("vector boot", resetVector, BOOT);
    // out of order loads, first one on the last chance of the window
    load(7'h05, 16'hA5C3, 3);
    load(7'h02, 16'h1234, 0);
    opPage(8'h83, 24'h0105FF, 1'b0);
    opPage(8'h05, 24'h010500, 1'b0);
    cpu.wrCtrl(8'h11);
    @(negedge clk);
    check("reenable", {rwReadBlock, ctrlRdData}, 9'h000);
    // command left without its store
    cpu.wrCtrl(8'h03);
    check("armed", ctrlRdData, 8'h03);
    cpu.spm(4);
    @(negedge clk);
    check("expired", {flashErase, ctrlRdData}, 9'h000);
    // halting section; the write sees a buffer emptied by the last write
    opPage(8'h03, 24'h01E000, 1'b1);
    opPage(8'h05, 24'h01E000, 1'b1);
    cpu.wrCtrl(8'h11);
    load(7'h03, 16'h0F0F, 0);
    cpu.wrCtrl(8'h11);
    clrBuf;
    opPage(8'h03, 24'h000300, 1'b0);
    load(7'h04, 16'h7E81, 1);
    opPage(8'h05, 24'h000300, 1'b0);
    // eeprom write in the middle of loading drops only what was loaded before it
    opPage(8'h03, 24'h000300, 1'b0);
    load(7'h06, 16'h3C3C, 2);
    cpu.strobe(1'b0);
    clrBuf;
    load(7'h07, 16'hC3A5, 0);
    opPage(8'h05, 24'h000300, 1'b0);
    // byte read keeps the lowest pointer bit
    cpu.setPtr(24'h01ABCD);
    cpu.strobe(1'b1);
    @(negedge clk);
    check("lpm", {lpmWordAddr, lpmByteSel}, 17'h1ABCD);
    check("vector kept", resetVector, BOOT);
    summarize();
  end
endmodule // testbench
`default_nettype wire
